/* design/ssf_pkg.sv */
/*
 * Constants shared by the serial status flag block: register offsets,
 * status and control bit positions and values after reset.
 * Assumes a register port with a two-bit word address.
 */
package ssf_pkg;

    // ------------------------------------------------------------
    // Register offsets (word index on the register port)
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_CTRL = 2'h1;
    localparam logic [1:0] ADDR_RX_DATA = 2'h2;
    localparam logic [1:0] ADDR_TX_DATA = 2'h3;

    // ------------------------------------------------------------
    // Status bit positions and reset value
    // ------------------------------------------------------------
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_RX_FULL = 6;
    localparam int BIT_OVERRUN = 5;
    localparam int BIT_FRAMING = 4;
    localparam int BIT_PARITY = 3;
    localparam int BIT_TX_DONE = 2;
    localparam int BIT_MP = 1;
    localparam logic [7:0] STATUS_RESET = 8'h84;
    // Flags that software clears by read-one then write-zero
    localparam logic [7:0] CLEARABLE = 8'hf8;

    // ------------------------------------------------------------
    // Control bit positions and reset value
    // ------------------------------------------------------------
    localparam int CTL_TX_EN = 0;
    localparam int CTL_RX_EN = 1;
    localparam int CTL_CARD = 2;
    localparam int CTL_SYNC = 3;
    localparam int CTL_PAR_EN = 4;
    localparam int CTL_PAR_ODD = 5;
    localparam int CTL_MP_FMT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

endpackage

/* design/ssf_status.sv */
/*
 * Status flag logic of a serial unit: the 8-bit serial status register
 * with its set and clear conditions, a control register, receive and
 * transmit holding registers, and the stall lines to the shift engines.
 * Assumes the shift engines run on clk and give one-cycle event pulses;
 * standby is a synchronous level from the chip's power logic.
 */
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module ssf_status (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic standby,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tx_take,
    input wire logic tx_last_bit,
    output logic tx_load,
    output logic [7:0] tx_char,
    input wire logic rx_done,
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_bit,
    input wire logic rx_mp_bit,
    input wire logic card_err_sample,
    input wire logic card_err_level,
    output logic rx_stall,
    output logic tx_stall,
    output logic transmit_enable,
    output logic receive_enable,
    output logic card_mode_select,
    output logic sync_mode
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] status_ff, nxt_status;
    logic [7:0] armed_ff, nxt_armed;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] rx_data_ff, nxt_rx_data;
    logic [7:0] tx_hold_ff, nxt_tx_hold;
    logic [7:0] tx_char_ff, nxt_tx_char;
    logic [7:0] rdata_ff, nxt_rdata;

    logic st_rd, st_wr;
    logic rx_accept, rx_ferr, rx_perr;
    logic par_en, par_odd, mp_fmt;

    // ------------------------------------------------------------
    // Decode and receive checks
    // ------------------------------------------------------------
    // Control fields
    assign transmit_enable = ctrl_ff[ssf_pkg::CTL_TX_EN];
    assign receive_enable = ctrl_ff[ssf_pkg::CTL_RX_EN];
    assign card_mode_select = ctrl_ff[ssf_pkg::CTL_CARD];
    assign sync_mode = ctrl_ff[ssf_pkg::CTL_SYNC];
    assign par_en = ctrl_ff[ssf_pkg::CTL_PAR_EN];
    assign par_odd = ctrl_ff[ssf_pkg::CTL_PAR_ODD];
    assign mp_fmt = ctrl_ff[ssf_pkg::CTL_MP_FMT];

    assign st_rd = reg_rd && (reg_addr == ssf_pkg::ADDR_STATUS);
    assign st_wr = reg_wr && (reg_addr == ssf_pkg::ADDR_STATUS);

    // Bit 4 stalls only as framing flag, not as card error signal
    assign rx_stall = status_ff[ssf_pkg::BIT_OVERRUN]
        || (status_ff[ssf_pkg::BIT_FRAMING] && !card_mode_select)
        || status_ff[ssf_pkg::BIT_PARITY];
    assign tx_stall = sync_mode && rx_stall;

    // Characters arriving while disabled or stalled are dropped
    assign rx_accept = rx_done && receive_enable && !rx_stall;
    // Only the first stop bit is presented, so the second is never seen
    assign rx_ferr = !sync_mode && !card_mode_select
        && !rx_stop_bit;
    // Odd parity wants an odd ones count over data and parity bit
    assign rx_perr = par_en && !sync_mode
        && ((^{rx_char, rx_parity_bit}) != par_odd);

    // Holding data goes to the shifter when it asks and data is valid
    assign tx_load = tx_take && transmit_enable && !tx_stall
        && !status_ff[ssf_pkg::BIT_TX_EMPTY];
    assign tx_char = tx_char_ff;
    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------
    // Status flags and armed bits
    // ------------------------------------------------------------
    // Software clear first, hardware events after so a set wins
    always_comb begin
        nxt_status = status_ff;
        nxt_armed = armed_ff;
        nxt_rx_data = rx_data_ff;
        // Reading a flag as one arms its clear
        if (st_rd) begin
            nxt_armed = armed_ff
                | (status_ff & ssf_pkg::CLEARABLE);
        end
        if (st_wr) begin
            // Ones ignored; read-only bits never taken from wdata
            for (int i = 3; i < 8; i++) begin
                if (!reg_wdata[i] && armed_ff[i]) begin
                    nxt_status[i] = 1'b0;
                end
            end
            // Clearing transmit-empty also clears transmit-finished
            if (!reg_wdata[ssf_pkg::BIT_TX_EMPTY]
                && armed_ff[ssf_pkg::BIT_TX_EMPTY]) begin
                nxt_status[ssf_pkg::BIT_TX_DONE] = 1'b0;
            end
            nxt_armed = 8'h00;
        end
        // Holding data moved into the shifter
        if (tx_load) begin
            nxt_status[ssf_pkg::BIT_TX_EMPTY] = 1'b1;
        end
        // Last bit left with no fresh data behind it
        if (tx_last_bit && status_ff[ssf_pkg::BIT_TX_EMPTY]) begin
            nxt_status[ssf_pkg::BIT_TX_DONE] = 1'b1;
        end
        // Transmit disabled pins both high; card error flag kept
        if (!transmit_enable) begin
            nxt_status[ssf_pkg::BIT_TX_EMPTY] = 1'b1;
            nxt_status[ssf_pkg::BIT_TX_DONE] = 1'b1;
        end
        // Receive disable itself touches no flag
        if (rx_accept) begin
            if (mp_fmt && !sync_mode) begin
                nxt_status[ssf_pkg::BIT_MP] = rx_mp_bit;
            end
            if (status_ff[ssf_pkg::BIT_RX_FULL]) begin
                // Old data kept, new character dropped
                nxt_status[ssf_pkg::BIT_OVERRUN] = 1'b1;
            end else if (rx_ferr || rx_perr) begin
                // Errored data still lands but is not flagged full
                nxt_rx_data = rx_char;
                if (rx_ferr) begin
                    nxt_status[ssf_pkg::BIT_FRAMING] = 1'b1;
                end
                if (rx_perr) begin
                    nxt_status[ssf_pkg::BIT_PARITY] = 1'b1;
                end
            end else begin
                nxt_rx_data = rx_char;
                nxt_status[ssf_pkg::BIT_RX_FULL] = 1'b1;
            end
        end
        // Error signal returned low by the card
        if (card_mode_select && card_err_sample && !card_err_level) begin
            nxt_status[ssf_pkg::BIT_FRAMING] = 1'b1;
        end
        // Standby overrides every flag and armed bit; receive data can still load
        if (standby) begin
            nxt_status = ssf_pkg::STATUS_RESET;
            nxt_armed = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= ssf_pkg::STATUS_RESET;
            armed_ff <= 8'h00;
            rx_data_ff <= ssf_pkg::DATA_RESET;
        end else begin
            status_ff <= nxt_status;
            armed_ff <= nxt_armed;
            rx_data_ff <= nxt_rx_data;
        end
    end

    // ------------------------------------------------------------
    // Control, transmit data and read port
    // ------------------------------------------------------------
    // Read data valid for one cycle only, zero otherwise
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_tx_hold = tx_hold_ff;
        nxt_tx_char = tx_char_ff;
        nxt_rdata = 8'h00;
        if (reg_wr && reg_addr == ssf_pkg::ADDR_CTRL) begin
            nxt_ctrl = reg_wdata;
        end
        if (reg_wr && reg_addr == ssf_pkg::ADDR_TX_DATA) begin
            nxt_tx_hold = reg_wdata;
        end
        if (tx_load) begin
            nxt_tx_char = tx_hold_ff;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ssf_pkg::ADDR_STATUS: nxt_rdata = status_ff;
                ssf_pkg::ADDR_CTRL: nxt_rdata = ctrl_ff;
                ssf_pkg::ADDR_RX_DATA: nxt_rdata = rx_data_ff;
                ssf_pkg::ADDR_TX_DATA: nxt_rdata = tx_hold_ff;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= ssf_pkg::CTRL_RESET;
            tx_hold_ff <= ssf_pkg::DATA_RESET;
            tx_char_ff <= ssf_pkg::DATA_RESET;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            tx_hold_ff <= nxt_tx_hold;
            tx_char_ff <= nxt_tx_char;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Standby forces the reset image
    property p_standby_image;
        @(posedge clk) disable iff (!rst_n)
        standby |=> status_ff == ssf_pkg::STATUS_RESET;
    endproperty
    a_standby_image: assert property (p_standby_image)
        else $error("status not reset image after standby");

    // Writing one never clears a set receive-full flag
    property p_one_ignored;
        @(posedge clk) disable iff (!rst_n)
        st_wr && reg_wdata[6] && status_ff[6] && !standby
        |=> status_ff[6];
    endproperty
    a_one_ignored: assert property (p_one_ignored)
        else $error("write of one cleared a flag");

    // Unarmed zero write leaves the flag set
    property p_unarmed;
        @(posedge clk) disable iff (!rst_n)
        st_wr && !reg_wdata[5] && !armed_ff[5] && status_ff[5]
        && !standby |=> status_ff[5];
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("unarmed zero write cleared overrun");

    // Read-only bits hold across a quiet write
    property p_read_only;
        @(posedge clk) disable iff (!rst_n)
        st_wr && reg_wdata[7] && transmit_enable && !tx_last_bit
        && !rx_done && !standby
        |=> status_ff[2:1] == $past(status_ff[2:1]);
    endproperty
    a_read_only: assert property (p_read_only)
        else $error("read-only status bit changed by write");

    // Read one, then zero write, clears transmit-empty and finished
    property p_tx_clear;
        @(posedge clk) disable iff (!rst_n)
        st_wr && !reg_wdata[7] && armed_ff[7]
        && transmit_enable && !tx_load && !tx_last_bit && !standby
        |=> !status_ff[7] && !status_ff[2];
    endproperty
    a_tx_clear: assert property (p_tx_clear)
        else $error("armed clear of transmit-empty failed");

    // Transmit disabled holds empty and finished high
    property p_tx_off;
        @(posedge clk) disable iff (!rst_n)
        !transmit_enable |=> status_ff[7] && status_ff[2];
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("flags not high with transmit disabled");

    // Clean character sets receive-full with its data
    property p_rx_good;
        @(posedge clk) disable iff (!rst_n)
        rx_accept && !status_ff[6] && !rx_ferr && !rx_perr && !standby
        |=> status_ff[6] && rx_data_ff == $past(rx_char);
    endproperty
    a_rx_good: assert property (p_rx_good)
        else $error("good character not flagged full");

    // Overrun keeps old data
    property p_overrun;
        @(posedge clk) disable iff (!rst_n)
        rx_accept && status_ff[6] && !standby
        |=> status_ff[5] && $stable(rx_data_ff);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged or data lost");

    // Framing error loads data without receive-full
    property p_framing;
        @(posedge clk) disable iff (!rst_n)
        rx_accept && !status_ff[6] && rx_ferr && !standby
        |=> status_ff[4] && !status_ff[6]
        && rx_data_ff == $past(rx_char);
    endproperty
    a_framing: assert property (p_framing)
        else $error("framing error handling wrong");

    // A set overrun flag blocks reception and, in sync, transmission
    property p_stall;
        @(posedge clk) disable iff (!rst_n)
        status_ff[5] |-> !rx_accept && (!sync_mode || !tx_load);
    endproperty
    a_stall: assert property (p_stall)
        else $error("activity while overrun set");

    // Card error signal sampled low sets bit 4
    property p_card_err;
        @(posedge clk) disable iff (!rst_n)
        card_mode_select && card_err_sample && !card_err_level
        && !standby |=> status_ff[4];
    endproperty
    a_card_err: assert property (p_card_err)
        else $error("card error signal not flagged");

    // Parity error flags bit 3 and leaves receive-full clear
    property p_parity;
        @(posedge clk) disable iff (!rst_n)
        rx_accept && !status_ff[6] && rx_perr && !standby
        |=> status_ff[3] && !status_ff[6];
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity error not flagged");

    // Accepted character in multiproc format copies its extra bit
    property p_mp_capture;
        @(posedge clk) disable iff (!rst_n)
        rx_accept && mp_fmt && !sync_mode && !standby
        |=> status_ff[1] == $past(rx_mp_bit);
    endproperty
    a_mp_capture: assert property (p_mp_capture)
        else $error("multiproc bit not captured");

    // Receive disabled: data, full, overrun and parity hold
    property p_rx_off_keep;
        @(posedge clk) disable iff (!rst_n)
        !receive_enable && !st_wr && !standby
        |=> $stable(status_ff[6:5]) && $stable(status_ff[3])
        && $stable(rx_data_ff);
    endproperty
    a_rx_off_keep: assert property (p_rx_off_keep)
        else $error("receive state changed while disabled");

    // Card error flag survives transmit disable
    property p_card_kept;
        @(posedge clk) disable iff (!rst_n)
        card_mode_select && status_ff[4] && !transmit_enable
        && !st_wr && !standby |=> status_ff[4];
    endproperty
    a_card_kept: assert property (p_card_kept)
        else $error("card error flag lost with transmit off");

    // Armed zero write clears overrun unless a new one arrives
    property p_overrun_clear;
        @(posedge clk) disable iff (!rst_n)
        st_wr && !reg_wdata[5] && armed_ff[5] && !rx_accept && !standby
        |=> !status_ff[5];
    endproperty
    a_overrun_clear: assert property (p_overrun_clear)
        else $error("armed zero write left overrun set");

endmodule

/* dv/ssf_line_model.sv */
/*
 * Far side of the serial unit: receive engine, transmit engine and the
 * card's returned error signal, each as one-cycle pulses on clk.
 * Assumes the bench calls its tasks, one at a time, between clock edges.
 */
`timescale 1ns/1ps
module ssf_line_model (
    input wire logic clk,
    input wire logic tx_load,
    output logic tx_take,
    output logic tx_last_bit,
    output logic rx_done,
    output logic [7:0] rx_char,
    output logic rx_parity_bit,
    output logic rx_stop_bit,
    output logic rx_mp_bit,
    output logic card_err_sample,
    output logic card_err_level
);
    // ----------------------------------------------------------
    // Idle values
    // ----------------------------------------------------------
    initial begin
        tx_take = 1'b0;
        tx_last_bit = 1'b0;
        rx_done = 1'b0;
        rx_char = 8'h00;
        rx_parity_bit = 1'b0;
        rx_stop_bit = 1'b1;
        rx_mp_bit = 1'b0;
        card_err_sample = 1'b0;
        card_err_level = 1'b1;
    end

    // Data only valid with the pulse; inverted after it so stale
    // values are never mistaken for fresh ones
    task automatic send(input logic [7:0] c, input logic p,
                        input logic s, input logic m);
        @(posedge clk);
        rx_done <= 1'b1;
        rx_char <= c;
        rx_parity_bit <= p;
        rx_stop_bit <= s; // First stop bit only
        rx_mp_bit <= m;
        @(posedge clk);
        rx_done <= 1'b0;
        rx_char <= ~c;
        rx_parity_bit <= ~p;
        rx_stop_bit <= ~s;
        rx_mp_bit <= ~m;
    endtask

    // Shifter asks for data; the load answer stands in the same cycle
    task automatic take(output logic seen);
        @(posedge clk);
        tx_take <= 1'b1;
        #1 seen = tx_load;
        @(posedge clk);
        tx_take <= 1'b0;
    endtask

    task automatic last_bit();
        @(posedge clk);
        tx_last_bit <= 1'b1;
        @(posedge clk);
        tx_last_bit <= 1'b0;
    endtask

    task automatic card_err(input logic lvl);
        @(posedge clk);
        card_err_sample <= 1'b1;
        card_err_level <= lvl;
        @(posedge clk);
        card_err_sample <= 1'b0;
        card_err_level <= ~lvl;
    endtask
endmodule

/* dv/ssf_status_tb.sv */
/*
 * Self-checking bench of the serial status flags, one task a scenario.
 * Assumes the design answers reads in the next cycle and that the line
 * model stands in for both shift engines.
 */
`timescale 1ns/1ps
module ssf_status_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic standby = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, tx_char, rx_char;
    logic tx_take, tx_last_bit, tx_load, rx_done, rx_parity_bit;
    logic rx_stop_bit, rx_mp_bit, card_err_sample, card_err_level;
    logic rx_stall, tx_stall, transmit_enable, receive_enable;
    logic card_mode_select, sync_mode, seen;
    int n_fail = 0;
    int cmp_count = 0;

    ssf_status ssf_status_inst (.clk(clk), .rst_n(rst_n),
        .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_take(tx_take), .tx_last_bit(tx_last_bit), .tx_load(tx_load),
        .tx_char(tx_char), .rx_done(rx_done), .rx_char(rx_char),
        .rx_parity_bit(rx_parity_bit), .rx_stop_bit(rx_stop_bit),
        .rx_mp_bit(rx_mp_bit), .card_err_sample(card_err_sample),
        .card_err_level(card_err_level), .rx_stall(rx_stall),
        .tx_stall(tx_stall), .transmit_enable(transmit_enable),
        .receive_enable(receive_enable),
        .card_mode_select(card_mode_select), .sync_mode(sync_mode));

    ssf_line_model ssf_line_model_inst (.clk(clk), .tx_load(tx_load),
        .tx_take(tx_take), .tx_last_bit(tx_last_bit), .rx_done(rx_done),
        .rx_char(rx_char), .rx_parity_bit(rx_parity_bit),
        .rx_stop_bit(rx_stop_bit), .rx_mp_bit(rx_mp_bit),
        .card_err_sample(card_err_sample),
        .card_err_level(card_err_level));

    // ----------------------------------------------------------
    // Clock, compares and register port
    // ----------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk8($sformatf("reg %0d", a), e, reg_rdata);
    endtask

    // Read arms the set flags, then zeros go only where the mask says
    task automatic clr(input logic [7:0] m, input logic [7:0] e);
        rchk(ssf_pkg::ADDR_STATUS, e);
        wr(ssf_pkg::ADDR_STATUS, ~m);
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        rchk(ssf_pkg::ADDR_CTRL, 8'h00);
        rchk(ssf_pkg::ADDR_RX_DATA, 8'h00);
        wr(ssf_pkg::ADDR_STATUS, 8'hff);
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        wr(ssf_pkg::ADDR_STATUS, 8'hff);
        wr(ssf_pkg::ADDR_STATUS, 8'h7f);
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        $display("test reset done");
    endtask

    task automatic t_tx();
        wr(ssf_pkg::ADDR_CTRL, 8'h01);
        wr(ssf_pkg::ADDR_TX_DATA, 8'ha5);
        clr(8'h80, 8'h84);
        wr(ssf_pkg::ADDR_STATUS, 8'hff);
        rchk(ssf_pkg::ADDR_STATUS, 8'h00);
        ssf_line_model_inst.take(seen);
        chk1("tx_load", 1'b1, seen);
        rchk(ssf_pkg::ADDR_STATUS, 8'h80);
        chk8("tx_char", 8'ha5, tx_char);
        ssf_line_model_inst.take(seen);
        chk1("tx_load", 1'b0, seen);
        ssf_line_model_inst.last_bit();
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        wr(ssf_pkg::ADDR_STATUS, 8'h7f);
        rchk(ssf_pkg::ADDR_STATUS, 8'h00);
        wr(ssf_pkg::ADDR_CTRL, 8'h00);
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        $display("test transmit done");
    endtask

    task automatic t_rx();
        wr(ssf_pkg::ADDR_CTRL, 8'h02);
        ssf_line_model_inst.send(8'h55, 1'b0, 1'b1, 1'b0);
        ssf_line_model_inst.send(8'h33, 1'b0, 1'b1, 1'b0);
        rchk(ssf_pkg::ADDR_STATUS, 8'he4);
        chk1("rx_stall", 1'b1, rx_stall);
        ssf_line_model_inst.send(8'h77, 1'b0, 1'b0, 1'b0);
        wr(ssf_pkg::ADDR_CTRL, 8'h00);
        rchk(ssf_pkg::ADDR_RX_DATA, 8'h55);
        wr(ssf_pkg::ADDR_STATUS, 8'hff);
        wr(ssf_pkg::ADDR_STATUS, 8'hdf);
        clr(8'h60, 8'he4);
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        chk1("rx_stall", 1'b0, rx_stall);
        $display("test receive done");
    endtask

    task automatic t_err();
        wr(ssf_pkg::ADDR_CTRL, 8'h02);
        ssf_line_model_inst.send(8'h3c, 1'b0, 1'b0, 1'b0);
        rchk(ssf_pkg::ADDR_RX_DATA, 8'h3c);
        chk1("tx_stall", 1'b0, tx_stall);
        wr(ssf_pkg::ADDR_CTRL, 8'h0a);
        #1 chk1("tx_stall", 1'b1, tx_stall);
        chk8("ctrl pins", 8'h0a, {4'h0, sync_mode, card_mode_select,
            receive_enable, transmit_enable});
        wr(ssf_pkg::ADDR_CTRL, 8'h12);
        clr(8'h10, 8'h94);
        ssf_line_model_inst.send(8'h01, 1'b0, 1'b1, 1'b0);
        clr(8'h08, 8'h8c);
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        wr(ssf_pkg::ADDR_CTRL, 8'h32);
        ssf_line_model_inst.send(8'h01, 1'b0, 1'b1, 1'b0);
        clr(8'h40, 8'hc4);
        $display("test errors done");
    endtask

    task automatic t_card();
        wr(ssf_pkg::ADDR_CTRL, 8'h05);
        ssf_line_model_inst.card_err(1'b1);
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        ssf_line_model_inst.card_err(1'b0);
        wr(ssf_pkg::ADDR_CTRL, 8'h04);
        rchk(ssf_pkg::ADDR_STATUS, 8'h94);
        chk1("rx_stall", 1'b0, rx_stall);
        wr(ssf_pkg::ADDR_STATUS, 8'hff);
        wr(ssf_pkg::ADDR_STATUS, 8'hef);
        clr(8'h10, 8'h94);
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        $display("test card done");
    endtask

    task automatic t_mp_standby();
        wr(ssf_pkg::ADDR_CTRL, 8'h42);
        ssf_line_model_inst.send(8'h11, 1'b0, 1'b1, 1'b1);
        wr(ssf_pkg::ADDR_STATUS, 8'hf9);
        rchk(ssf_pkg::ADDR_STATUS, 8'hc6);
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        rchk(ssf_pkg::ADDR_STATUS, 8'h84);
        $display("test multiproc and standby done");
    endtask

    // ----------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_err();
        t_card();
        t_mp_standby();
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("ERROR run length expected end seen timeout");
        results();
    end
endmodule
